// ### bench/decode_monitor.sv
// Port-level checker for the decode core
`timescale 1ns/1ps
module decode_monitor (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       nrst,
  // Program memory
  input wire logic       memReq,
  input wire logic       memOperand,
  input wire logic [7:0] memData,
  input wire logic       memValid,
  // Processor state
  input wire logic [7:0] acc,
  input wire logic       carry,
  input wire logic       zero,
  input wire logic       halted,
  input wire logic       instrDone,
  input wire logic       badOpcode,
  input wire logic       irqRequest
);
  logic take;
  logic opTake;
  logic isShort;
  logic isOperand;
  assign take      = memReq && memValid && !memOperand;
  assign opTake    = memReq && memValid && memOperand;
  assign isShort   = (memData inside {8'h00, 8'h07, 8'h0F, 8'h17, 8'h1F, 8'h27, 8'h2F,
                      8'h37, 8'h3F, 8'h20, 8'h30, 8'hFB, 8'hF3})
                     || (memData[7:5] == 3'h5 && memData[2:0] != 3'h6);
  assign isOperand = memData[7] && memData[5] && memData[2:0] == 3'h6;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  property rot_left_p;
    logic [7:0] v;
    (take && memData == 8'h07, v = acc) |-> ##4 acc == {v[6:0], v[7]} && carry == v[7];
  endproperty
  property invert_p;
    logic [7:0] v;
    (take && memData == 8'h2F, v = acc) |-> ##4 acc == ~v;
  endproperty
  AST_SHORT_LEN: assert property (take && isShort |=> !instrDone [*3] ##1 instrDone)
    else $error("short opcode did not finish in four cycles");
  AST_OPERAND_REQ: assert property (take && isOperand |=> memReq && memOperand)
    else $error("operand byte not requested after operand opcode");
  AST_OPERAND_LEN: assert property (opTake |=> !instrDone [*5] ##1 instrDone)
    else $error("operand form did not finish seven cycles after opcode");
  AST_HALT_LEN: assert property (take && memData == 8'h76 |=> !instrDone [*4] ##1 instrDone ##[0:1] halted)
    else $error("halt did not take five cycles");
  AST_HALT_NO_FETCH: assert property (halted |-> !memReq)
    else $error("fetch requested while halted");
  AST_BAD_WITH_DONE: assert property (badOpcode |-> instrDone)
    else $error("unknown opcode flag without completion");
  AST_DONE_PULSE: assert property (instrDone |=> !instrDone)
    else $error("completion pulse longer than one cycle");
  AST_ROT_LEFT: assert property (rot_left_p)
    else $error("rotate left gave a wrong result");
  AST_INVERT: assert property (invert_p)
    else $error("accumulator invert gave a wrong result");
  AST_XOR_SELF: assert property (take && memData == 8'hAF |-> ##4 acc == 8'h00 && zero)
    else $error("xor of accumulator with itself not zero");
  AST_DI_QUIET: assert property (take && memData == 8'hF3 |-> ##7 !irqRequest)
    else $error("interrupt request stayed up after disable");
  cover property (take && memData == 8'h30);
  cover property (opTake);
  cover property ($fell(halted));
endmodule // decode_monitor

bind logic_rotate_irq_mask_decode decode_monitor u_decode_monitor (
  .mclk(mclk), .nrst(nrst), .memReq(memReq), .memOperand(memOperand), .memData(memData),
  .memValid(memValid), .acc(acc), .carry(carry), .zero(zero), .halted(halted),
  .instrDone(instrDone), .badOpcode(badOpcode), .irqRequest(irqRequest));

// ### bench/logic_rotate_irq_mask_decode_test.sv
// Self-checking bench for the decode core with a program memory model
`timescale 1ns/1ps
module logic_rotate_irq_mask_decode_test;
  typedef struct packed {
    logic [7:0] acc;
    logic       c;
    logic       chkC;
    logic       bad;
    logic [3:0] flg;
    logic       chkF;
  } note_type;
  logic        mclk, nrst, memReq, memOperand, memValid, regWe, stall, c;
  logic        topIrq, midIrq, lowIrq, carry, auxCarry, zero, sign, parity;
  logic        halted, instrDone, badOpcode, irqRequest;
  logic [15:0] memAddr, ea;
  logic [15:0] aq [$];
  logic [7:0]  memData, regData, acc, progLen, a, v;
  logic [7:0]  r [0:7];
  logic [2:0]  regSel;
  logic [31:0] seed;
  note_type    q [$];
  note_type    e;
  int          failures, checks, n;

  logic_rotate_irq_mask_decode u_logic_rotate_irq_mask_decode (
    .mclk(mclk), .nrst(nrst), .memReq(memReq), .memOperand(memOperand), .memAddr(memAddr),
    .memData(memData), .memValid(memValid), .regWe(regWe), .regSel(regSel),
    .regData(regData), .topIrq(topIrq), .midIrq(midIrq), .lowIrq(lowIrq), .acc(acc),
    .carry(carry), .auxCarry(auxCarry), .zero(zero), .sign(sign), .parity(parity),
    .halted(halted),
    .instrDone(instrDone), .badOpcode(badOpcode), .irqRequest(irqRequest));
  prog_mem_model u_prog_mem_model (
    .mclk(mclk), .nrst(nrst), .memReq(memReq), .memData(memData), .memValid(memValid),
    .stall(stall), .progLen(progLen));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("Checks %0d, failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task put(input logic [7:0] b);
    u_prog_mem_model.mem[n] = b;
    n++;
  endtask
  task step(input logic [7:0] b, input logic bad);
    put(b);
    q.push_back('{a, c, 1'b1, bad, 4'h0, 1'b0});
  endtask
  task alu(input logic [1:0] op, input logic [7:0] s);
    logic [7:0] f;
    logic       h;
    f = a - s;
    h = op == 2'h0 || (op == 2'h3 && a[3:0] < s[3:0]);
    case (op)
      2'h0: a = a & s;
      2'h1: begin
        a = a ^ s;
        c = 1'b0;
      end
      2'h2: begin
        a = a | s;
        c = 1'b0;
      end
      default: c = a < s;
    endcase
    // Carry after AND is left open, so it is not compared
    if (op != 2'h3) f = a;
    q.push_back('{a, c, op != 2'h0, 1'b0, {h, f[7], f == 8'h00, ~^f}, 1'b1});
  endtask
  task imm(input logic [1:0] op, input logic [7:0] s);
    aq.push_back(16'h0000);
    put({3'h7, op, 3'h6});
    put(s);
    alu(op, s);
  endtask

  // Random stalls on every byte, opcode or operand, from the memory side
  always @(posedge mclk) stall <= ($random(seed) % 4) == 0;

  // Outputs are judged only after reset has been applied
  always @(posedge mclk) begin
    if (nrst === 1'b1 && instrDone === 1'b1) begin
      if (q.size() == 0) check(8'h01, 8'h00);
      else begin
        e = q.pop_front();
        check(acc, e.acc);
        if (e.chkC) check({7'h00, carry}, {7'h00, e.c});
        check({7'h00, badOpcode}, {7'h00, e.bad});
        if (e.chkF) check({4'h0, auxCarry, sign, zero, parity}, {4'h0, e.flg});
      end
    end
    if (nrst === 1'b1 && memOperand === 1'b1 && memValid === 1'b1) begin
      ea = aq.pop_front();
      check(memAddr[15:8], ea[15:8]);
      check(memAddr[7:0], ea[7:0]);
    end
  end

  initial begin
    #80000;
    failures++;
    $display("ERROR at %0t: watchdog expired with %0d results pending", $time, q.size());
    end_of_test;
  end

  initial begin
    seed = 32'he49f_862f;
    nrst = 1'b0;
    regWe = 1'b0;
    regSel = 3'h0;
    regData = 8'h00;
    topIrq = 1'b0;
    midIrq = 1'b1;
    lowIrq = 1'b0;
    progLen = 8'h00;
    n = 0;
    failures = 0;
    checks = 0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (i != 6) begin
        @(posedge mclk);
        v = 8'($random(seed));
        r[i] = v;
        regWe <= 1'b1;
        regSel <= i[2:0];
        regData <= v;
      end
    end
    @(posedge mclk);
    regWe <= 1'b0;
    topIrq <= 1'b1;
    lowIrq <= 1'b1;
    a = r[7];
    c = 1'b0;
    for (int o = 0; o < 4; o++) begin
      for (int s = 0; s < 8; s++) begin
        put({3'h5, o[1:0], s[2:0]});
        if (s == 6) begin
          v = 8'($random(seed));
          put(v);
          aq.push_back({r[4], r[5]});
          alu(o[1:0], v);
        end else alu(o[1:0], s == 7 ? a : r[s]);
      end
      imm(o[1:0], 8'($random(seed)));
    end
    c = a[7];
    a = {a[6:0], a[7]};
    step(8'h07, 1'b0);
    c = a[0];
    a = {a[0], a[7:1]};
    step(8'h0F, 1'b0);
    {c, a} = {a, c};
    step(8'h17, 1'b0);
    {a, c} = {c, a};
    step(8'h1F, 1'b0);
    a = ~a;
    step(8'h2F, 1'b0);
    c = 1'b1;
    step(8'h37, 1'b0);
    c = ~c;
    step(8'h3F, 1'b0);
    step(8'h08, 1'b1);
    step(8'h00, 1'b0);
    imm(2'h1, a);
    imm(2'h2, 8'h9A);
    a = 8'h00;
    c = 1'b1;
    step(8'h27, 1'b0);
    step(8'hFB, 1'b0);
    for (int k = 0; k < 3; k++) begin
      if (k == 2) step(8'hF3, 1'b0);
      imm(2'h1, a);
      imm(2'h2, k == 0 ? 8'h0A : k == 1 ? 8'h10 : 8'h08);
      step(8'h30, 1'b0);
      a = k == 0 ? 8'h7A : k == 1 ? 8'h3A : 8'h30;
      step(8'h20, 1'b0);
    end
    step(8'hFB, 1'b0);
    step(8'h76, 1'b0);
    step(8'h00, 1'b0);
    progLen <= n[7:0];
    for (int t = 0; t < 5000 && q.size() > 0; t++) @(posedge mclk);
    check(8'(q.size()), 8'h00);
    $display("Test program_run done");
    end_of_test;
  end
endmodule // logic_rotate_irq_mask_decode_test

// ### bench/prog_mem_model.sv
// Program memory model serving one byte stream to the decode core
`timescale 1ns/1ps
module prog_mem_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // Core side
  input  wire logic       memReq,
  output logic [7:0]      memData,
  output logic            memValid,
  // Bench control
  input  wire logic       stall,
  input  wire logic [7:0] progLen
);
  logic [7:0] mem [0:255];
  logic [7:0] ptr;
  logic [7:0] last;
  // Idle bus shows the inverse of the last byte, never a held copy
  assign memValid = nrst && !stall && (ptr < progLen);
  assign memData  = memValid ? mem[ptr] : ~last;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ptr  <= 8'h00;
      last <= 8'h00;
    end else if (memReq && memValid) begin
      ptr  <= ptr + 8'h01;
      last <= mem[ptr];
    end
  end
endmodule // prog_mem_model

// ### rtl/cpu_core_pkg.sv
// Constants for the logical, rotate, control and interrupt-mask decode core
package cpu_core_pkg;
  // Fixed opcodes
  localparam logic [7:0] IDLE_OP              = 8'h00;
  localparam logic [7:0] HALT_OP              = 8'h76;
  localparam logic [7:0] ROT_LEFT_OP          = 8'h07;
  localparam logic [7:0] ROT_RIGHT_OP         = 8'h0F;
  localparam logic [7:0] ROT_LEFT_THRU_CARRY  = 8'h17;
  localparam logic [7:0] ROT_RIGHT_THRU_CARRY = 8'h1F;
  localparam logic [7:0] BCD_ADJUST_OP        = 8'h27;
  localparam logic [7:0] ACC_INVERT_OP        = 8'h2F;
  localparam logic [7:0] CARRY_SET_OP         = 8'h37;
  localparam logic [7:0] CARRY_FLIP_OP        = 8'h3F;
  localparam logic [7:0] IRQ_STATUS_READ_OP   = 8'h20;
  localparam logic [7:0] IRQ_MASK_SET_OP      = 8'h30;
  localparam logic [7:0] IRQ_ON_OP            = 8'hFB;
  localparam logic [7:0] IRQ_OFF_OP           = 8'hF3;
  // Logical group: bits 7..5 of register form and immediate form
  localparam logic [2:0] LOGIC_REG_GROUP      = 3'h5;
  localparam logic [2:0] LOGIC_IMM_GROUP      = 3'h7;
  localparam logic [1:0] ALU_AND              = 2'h0;
  localparam logic [1:0] ALU_XOR              = 2'h1;
  localparam logic [1:0] ALU_OR               = 2'h2;
  localparam logic [1:0] ALU_CMP              = 2'h3;
  // Register select codes
  localparam logic [2:0] SEL_B                = 3'h0;
  localparam logic [2:0] SEL_C                = 3'h1;
  localparam logic [2:0] SEL_D                = 3'h2;
  localparam logic [2:0] SEL_E                = 3'h3;
  localparam logic [2:0] SEL_H                = 3'h4;
  localparam logic [2:0] SEL_L                = 3'h5;
  localparam logic [2:0] SEL_MEM              = 3'h6;
  localparam logic [2:0] SEL_ACC              = 3'h7;
  // Instruction lengths in clock cycles and the cycle counter width
  localparam int         CYC_SHORT            = 4;
  localparam int         CYC_OPERAND          = 7;
  localparam int         CYC_HALT             = 5;
  localparam int         CNT_W                = 3;
  // Mask control word and status word fields
  localparam int         CW_EDGE_CLR          = 4;
  localparam int         CW_MASK_WE           = 3;
  localparam int         ST_PEND_TOP          = 6;
  localparam int         ST_PEND_MID          = 5;
  localparam int         ST_PEND_LOW          = 4;
  localparam int         ST_IE                = 3;
  // Reset values and decimal adjust constants
  localparam logic [2:0] MASK_RESET           = 3'h7;
  localparam logic       IE_RESET             = 1'b0;
  localparam logic [7:0] ACC_RESET            = 8'h00;
  localparam logic [7:0] BCD_SIX              = 8'h06;
  localparam logic [7:0] BCD_SIXTY            = 8'h60;
  localparam logic [7:0] BCD_MAX              = 8'h99;
  localparam logic [3:0] BCD_DIGIT_MAX        = 4'h9;

  typedef enum logic [3:0] {
    FETCH   = 4'b0001,
    OPERAND = 4'b0010,
    EXEC    = 4'b0100,
    HALTED  = 4'b1000
  } core_state_type;
endpackage

// ### rtl/irq_ctrl_if.sv
// Carrier between the decode core and the interrupt mask unit
`timescale 1ns/1ps
interface irq_ctrl_if;
  logic       maskWrite;
  logic [7:0] ctrlWord;
  logic       ieSet;
  logic       ieClr;
  logic [7:0] statusWord;
  logic       wake;
  modport core (output maskWrite, output ctrlWord, output ieSet, output ieClr,
                input statusWord, input wake);
  modport unit (input maskWrite, input ctrlWord, input ieSet, input ieClr,
                output statusWord, output wake);
endinterface

// ### rtl/irq_mask_unit.sv
// Interrupt masks, edge latch, enable flag and status word
`timescale 1ns/1ps
module irq_mask_unit (
  // Clock and reset
  input  wire logic   mclk,
  input  wire logic   nrst,
  // Request lines
  input  wire logic   topIrq,
  input  wire logic   midIrq,
  input  wire logic   lowIrq,
  // Core side
  irq_ctrl_if.unit    bus
);
  logic [2:0] masks;
  logic       ieFlag;
  logic       topPrev;
  logic       topLatch;
  logic       wakeReg;
  logic       edgeClr;

  assign edgeClr = bus.maskWrite & bus.ctrlWord[cpu_core_pkg::CW_EDGE_CLR];

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      masks <= cpu_core_pkg::MASK_RESET;
    end else if (bus.maskWrite && bus.ctrlWord[cpu_core_pkg::CW_MASK_WE]) begin
      masks <= bus.ctrlWord[2:0];  // [RULE9] [RULE10]
    end
  end

  // A new edge in the clearing cycle survives
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      topPrev  <= 1'b0;
      topLatch <= 1'b0;
    end else begin
      topPrev  <= topIrq;
      topLatch <= (topIrq & ~topPrev) | (topLatch & ~edgeClr);  // [RULE8]
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ieFlag <= cpu_core_pkg::IE_RESET;
    end else if (bus.ieSet) begin
      ieFlag <= 1'b1;  // [RULE6]
    end else if (bus.ieClr) begin
      ieFlag <= 1'b0;  // [RULE6]
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      wakeReg <= 1'b0;
    end else begin
      wakeReg <= ieFlag & |({topLatch, midIrq, lowIrq} & ~masks);
    end
  end

  always_comb begin
    bus.statusWord = 8'h00;
    bus.statusWord[cpu_core_pkg::ST_PEND_TOP] = topLatch;  // [RULE12]
    bus.statusWord[cpu_core_pkg::ST_PEND_MID] = midIrq;    // [RULE12]
    bus.statusWord[cpu_core_pkg::ST_PEND_LOW] = lowIrq;    // [RULE12]
    bus.statusWord[cpu_core_pkg::ST_IE]       = ieFlag;    // [RULE6]
    bus.statusWord[2:0]                       = masks;     // [RULE13]
  end

  assign bus.wake = wakeReg;
endmodule  // irq_mask_unit

// ### rtl/logic_rotate_irq_mask_decode.sv
// Decode and execute core for logical, rotate, special and control opcodes
//
// What this block does
// RULE1 - Register AND/XOR/OR/compare as 10100sss..10111sss, four cycles each unless sss is 110.
// RULE2 - Source field 110 takes the operand from memory, seven cycles.
// RULE3 - Immediate AND/XOR/OR/compare opcodes take the next byte, seven cycles.
// RULE4 - Register codes: B 000 to L 101, memory 110, accumulator 111.
// RULE5 - Rotates, invert, carry set, carry flip and decimal adjust, four cycles.
// RULE6 - Enable and disable opcodes set and clear the enable flag, read back on bit 3.
// RULE7 - Mask-set takes four cycles and uses the accumulator as control word.
// RULE8 - Mask-set with bit 4 high clears the top interrupt edge latch.
// RULE9 - Masks load from bits 2..0 only when bit 3 enables the write.
// RULE10 - Written ones mask top, middle and low interrupts; zeros unmask.
// RULE11 - Status-read takes four cycles and loads the status word to accumulator.
// RULE12 - Status bits 6, 5, 4 show top, middle, low interrupts pending.
// RULE13 - Status bits 2, 1, 0 show the current masks.
// RULE14 - Outside holds reset low until the oscillator is stable.
// RULE15 - Outside ignores outputs until the first reset has been applied.
// RULE16 - Opcode 00 idles four cycles; halt takes five, then waits for interrupt.
`timescale 1ns/1ps
module logic_rotate_irq_mask_decode (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // Program memory
  output logic             memReq,
  output logic             memOperand,
  output logic [15:0]      memAddr,
  input  wire logic [7:0]  memData,
  input  wire logic        memValid,
  // Register preload
  input  wire logic        regWe,
  input  wire logic [2:0]  regSel,
  input  wire logic [7:0]  regData,
  // Interrupt request lines
  input  wire logic        topIrq,
  input  wire logic        midIrq,
  input  wire logic        lowIrq,
  // Processor state
  output logic [7:0]       acc,
  output logic             carry,
  output logic             auxCarry,
  output logic             zero,
  output logic             sign,
  output logic             parity,
  output logic             halted,
  output logic             instrDone,
  output logic             badOpcode,
  output logic             irqRequest
);
  cpu_core_pkg::core_state_type           state;
  cpu_core_pkg::core_state_type           next_state;
  logic [cpu_core_pkg::CNT_W-1:0]         cnt;
  logic [7:0]                             opcode;
  logic [7:0]                             operand;
  logic [7:0]                             regFile [6];
  logic                                   finish;
  logic                                   fetchTake;
  logic [7:0]                             srcVal;
  logic [7:0]                             next_acc;
  logic                                   next_carry;
  logic                                   next_aux;
  logic                                   updSzp;
  logic [7:0]                             szpVal;
  logic [8:0]                             diff;
  logic [7:0]                             corr;
  irq_ctrl_if                             irqBus ();

  function automatic logic isLogicReg(input logic [7:0] op);
    return op[7:5] == cpu_core_pkg::LOGIC_REG_GROUP;  // [RULE1]
  endfunction

  function automatic logic isLogicImm(input logic [7:0] op);
    return op[7:5] == cpu_core_pkg::LOGIC_IMM_GROUP && op[2:0] == cpu_core_pkg::SEL_MEM;  // [RULE3]
  endfunction

  function automatic logic needsOperand(input logic [7:0] op);
    return isLogicImm(op) || (isLogicReg(op) && op[2:0] == cpu_core_pkg::SEL_MEM);  // [RULE2]
  endfunction

  // Count hits zero in the last cycle; opcode cycle and last cycle both included
  function automatic logic [cpu_core_pkg::CNT_W-1:0] cycLoad(input logic [7:0] op);
    if (needsOperand(op)) begin
      return cpu_core_pkg::CNT_W'(cpu_core_pkg::CYC_OPERAND - 2);  // [RULE2] [RULE3]
    end else if (op == cpu_core_pkg::HALT_OP) begin
      return cpu_core_pkg::CNT_W'(cpu_core_pkg::CYC_HALT - 2);  // [RULE16]
    end
    return cpu_core_pkg::CNT_W'(cpu_core_pkg::CYC_SHORT - 2);  // [RULE1] [RULE5] [RULE16]
  endfunction

  function automatic logic isKnown(input logic [7:0] op);
    unique case (op)
      cpu_core_pkg::IDLE_OP, cpu_core_pkg::HALT_OP, cpu_core_pkg::ROT_LEFT_OP,
      cpu_core_pkg::ROT_RIGHT_OP, cpu_core_pkg::ROT_LEFT_THRU_CARRY,
      cpu_core_pkg::ROT_RIGHT_THRU_CARRY, cpu_core_pkg::BCD_ADJUST_OP,
      cpu_core_pkg::ACC_INVERT_OP, cpu_core_pkg::CARRY_SET_OP, cpu_core_pkg::CARRY_FLIP_OP,
      cpu_core_pkg::IRQ_STATUS_READ_OP, cpu_core_pkg::IRQ_MASK_SET_OP,
      cpu_core_pkg::IRQ_ON_OP, cpu_core_pkg::IRQ_OFF_OP: return 1'b1;
      default: return isLogicReg(op) || isLogicImm(op);
    endcase
  endfunction

  assign fetchTake = state == cpu_core_pkg::FETCH && memValid;
  assign finish    = state == cpu_core_pkg::EXEC && cnt == '0;

  always_comb begin
    next_state = state;
    unique case (state)
      cpu_core_pkg::FETCH: begin
        if (memValid) begin
          next_state = needsOperand(memData) ? cpu_core_pkg::OPERAND : cpu_core_pkg::EXEC;
        end
      end
      cpu_core_pkg::OPERAND: begin
        if (memValid) begin
          next_state = cpu_core_pkg::EXEC;
        end
      end
      cpu_core_pkg::EXEC: begin
        if (cnt == '0) begin
          next_state = opcode == cpu_core_pkg::HALT_OP ? cpu_core_pkg::HALTED  // [RULE16]
                                                       : cpu_core_pkg::FETCH;
        end
      end
      cpu_core_pkg::HALTED: begin
        if (irqBus.wake) begin
          next_state = cpu_core_pkg::FETCH;  // [RULE16]
        end
      end
      default: next_state = cpu_core_pkg::FETCH;
    endcase
  end

  // Sequencer; a slow operand stretches the instruction past its nominal length
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state      <= cpu_core_pkg::FETCH;
      cnt        <= '0;
      opcode     <= cpu_core_pkg::IDLE_OP;
      operand    <= 8'h00;
      memReq     <= 1'b1;
      memOperand <= 1'b0;
      memAddr    <= 16'h0000;
      halted     <= 1'b0;
    end else begin
      state      <= next_state;
      memReq     <= next_state == cpu_core_pkg::FETCH || next_state == cpu_core_pkg::OPERAND;
      memOperand <= next_state == cpu_core_pkg::OPERAND;
      halted     <= next_state == cpu_core_pkg::HALTED;
      if (fetchTake) begin
        opcode  <= memData;
        cnt     <= cycLoad(memData);
        memAddr <= isLogicReg(memData) ? {regFile[cpu_core_pkg::SEL_H],
                                          regFile[cpu_core_pkg::SEL_L]} : 16'h0000;  // [RULE2]
      end else if (cnt != '0 && (state != cpu_core_pkg::OPERAND || memValid)) begin
        cnt <= cnt - 1'b1;
      end
      if (state == cpu_core_pkg::OPERAND && memValid) begin
        operand <= memData;
      end
    end
  end

  always_comb begin
    unique case (opcode[2:0])  // [RULE4]
      cpu_core_pkg::SEL_ACC: srcVal = acc;
      cpu_core_pkg::SEL_MEM: srcVal = operand;
      default:               srcVal = regFile[opcode[2:0]];
    endcase
    if (isLogicImm(opcode)) begin
      srcVal = operand;
    end
  end

  always_comb begin
    next_acc   = acc;
    next_carry = carry;
    next_aux   = auxCarry;
    updSzp     = 1'b0;
    szpVal     = acc;
    diff       = {1'b0, acc} - {1'b0, srcVal};
    corr       = 8'h00;
    if (isLogicReg(opcode) || isLogicImm(opcode)) begin
      updSzp = 1'b1;
      unique case (opcode[4:3])  // [RULE1] [RULE3]
        cpu_core_pkg::ALU_AND: begin
          next_acc = acc & srcVal;
          next_carry = 1'b0;
          next_aux = 1'b1;
        end
        cpu_core_pkg::ALU_XOR: begin
          next_acc = acc ^ srcVal;
          next_carry = 1'b0;
          next_aux = 1'b0;
        end
        cpu_core_pkg::ALU_OR: begin
          next_acc = acc | srcVal;
          next_carry = 1'b0;
          next_aux = 1'b0;
        end
        cpu_core_pkg::ALU_CMP: begin
          next_carry = diff[8];
          next_aux = acc[3:0] < srcVal[3:0];
        end
      endcase
      szpVal = opcode[4:3] == cpu_core_pkg::ALU_CMP ? diff[7:0] : next_acc;
    end else begin
      case (opcode)  // [RULE5]
        cpu_core_pkg::ROT_LEFT_OP: {next_carry, next_acc} = {acc[7], acc[6:0], acc[7]};
        cpu_core_pkg::ROT_RIGHT_OP: {next_carry, next_acc} = {acc[0], acc[0], acc[7:1]};
        cpu_core_pkg::ROT_LEFT_THRU_CARRY: {next_carry, next_acc} = {acc, carry};
        cpu_core_pkg::ROT_RIGHT_THRU_CARRY: {next_acc, next_carry} = {carry, acc};
        cpu_core_pkg::ACC_INVERT_OP: next_acc = ~acc;
        cpu_core_pkg::CARRY_SET_OP: next_carry = 1'b1;
        cpu_core_pkg::CARRY_FLIP_OP: next_carry = ~carry;
        cpu_core_pkg::BCD_ADJUST_OP: begin
          if (acc[3:0] > cpu_core_pkg::BCD_DIGIT_MAX || auxCarry) begin
            corr = cpu_core_pkg::BCD_SIX;
          end
          if (acc > cpu_core_pkg::BCD_MAX || carry) begin
            corr = corr | cpu_core_pkg::BCD_SIXTY;
            next_carry = 1'b1;
          end
          next_acc = acc + corr;
          next_aux = ({1'b0, acc[3:0]} + {1'b0, corr[3:0]}) > 5'h0F;
          updSzp = 1'b1;
          szpVal = next_acc;
        end
        cpu_core_pkg::IRQ_STATUS_READ_OP: next_acc = irqBus.statusWord;  // [RULE11]
        default: next_acc = acc;
      endcase
    end
  end

  assign irqBus.maskWrite = finish && opcode == cpu_core_pkg::IRQ_MASK_SET_OP;  // [RULE7]
  assign irqBus.ctrlWord  = acc;  // [RULE7]
  assign irqBus.ieSet     = finish && opcode == cpu_core_pkg::IRQ_ON_OP;  // [RULE6]
  assign irqBus.ieClr     = finish && opcode == cpu_core_pkg::IRQ_OFF_OP;  // [RULE6]

  // Preload is overridden by any finishing instruction, since each one writes the accumulator
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      acc      <= cpu_core_pkg::ACC_RESET;
      carry    <= 1'b0;
      auxCarry <= 1'b0;
      zero     <= 1'b0;
      sign     <= 1'b0;
      parity   <= 1'b0;
    end else begin
      if (regWe && regSel == cpu_core_pkg::SEL_ACC) begin
        acc <= regData;
      end
      if (finish) begin
        acc      <= next_acc;
        carry    <= next_carry;
        auxCarry <= next_aux;
        if (updSzp) begin
          zero   <= szpVal == 8'h00;
          sign   <= szpVal[7];
          parity <= ~^szpVal;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      regFile <= '{default: 8'h00};
    end else if (regWe && regSel < cpu_core_pkg::SEL_MEM) begin
      regFile[regSel] <= regData;  // [RULE4]
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      instrDone  <= 1'b0;
      badOpcode  <= 1'b0;
      irqRequest <= 1'b0;
    end else begin
      instrDone  <= finish;
      badOpcode  <= finish && !isKnown(opcode);
      irqRequest <= irqBus.wake;
    end
  end

  irq_mask_unit irqUnit (
    .mclk   (mclk),
    .nrst   (nrst),
    .topIrq (topIrq),
    .midIrq (midIrq),
    .lowIrq (lowIrq),
    .bus    (irqBus.unit)
  );
endmodule  // logic_rotate_irq_mask_decode
